/* File: hdl/dsd_frame.sv */
// Purpose: builds and streams the sixteen-byte slave diagnostic block
// Assumes: byteReady from the protocol engine on the same clock
// Notes: byte 4 holds ident high, byte 5 ident low
`timescale 1ns/1ns
`default_nettype none
`include "dsd_defines.svh"

// Summary of operation
// [R1] The block sent is six standard bytes followed by ten device bytes, sixteen in all.
// [R2] A block is sent on each master request and on each error event; the code keeps one pending flag, so several during a frame give one block.
// [R3] Host bytes become bytes 11 to 15 and a host status change can start a report.
// [R4] Byte 0 has zeros in bits 0, 5, 7 and status flags in bits 1, 2, 3, 4, 6.
// [R5] Byte 1 has flags in bits 0, 1, 3, 4, 5, a one in bit 2 and zeros in bits 6 and 7.
// [R6] Byte 2 has bits 0 to 6 zero and bit 7 showing diagnostic overflow.
// [R7] Byte 3 is the address of the master that last parametrized the slave.
// [R8] Byte 6 gives length and type of the device section.
// [R9] Byte 7 is a message code and byte 8 is reserved zero.
// [R10] Byte 4 is the ident high byte and byte 5 the ident low byte.
// [R11] Byte 6 is length ten in bits 0 to 5 and code zero in bits 6 and 7.
// [R12] Byte 7 takes the error codes from the engine or the user-valid code.
// [R13] A host status bit 0 rise starts a report; bit 1 marks deletion valid.
// [R14] A host status value of both bits set is ignored and starts nothing.
module dsd_frame
  import dsd_pkg::*;
#(
  parameter logic [15:0] IDENT = `DSD_IDENT_DEFAULT // Arbitrary value
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic masterRequest,
  input wire logic errorEvent,
  input wire logic [7:0] errorCode,
  input wire dsd_flags_t flags,
  input wire logic [7:0] masterAddr,
  input wire logic [7:0] hostStatus,
  input wire logic [39:0] hostData,
  input wire logic byteReady,
  output logic [7:0] txByte,
  output logic txValid,
  output logic txLast,
  output logic busy
);
  dsd_regs_t r;
  dsd_regs_t next_r;
  logic hostStart;
  logic [7:0] frameByte;

  // Rise of valid bit, but a valid-plus-delete value never starts
  assign hostStart = hostStatus[`DSD_STAT_VALID_BIT] && !r.prevStatus[`DSD_STAT_VALID_BIT]
                     && (hostStatus != `DSD_STAT_IGNORED); // see [R13] see [R14]

  always_comb begin
    next_r = r;
    frameByte = 8'h00;
    next_r.prevStatus = hostStatus;
    // Requests during a frame are held in one pending flag, so several give one more frame
    if (masterRequest || errorEvent || hostStart) begin // see [R2]
      next_r.pending = 1'b1;
    end
    if (errorEvent) begin
      next_r.message = errorCode; // see [R12]
    end else if (hostStart) begin
      next_r.message = `DSD_CODE_USER_VALID;
    end
    // Host bytes are taken even when an error claims byte 7
    if (hostStart) begin
      next_r.user = hostData; // see [R3]
    end
    case (r.state)
      DSD_IDLE: begin
        if (r.pending) begin
          next_r.pending = masterRequest || errorEvent || hostStart;
          next_r.state = DSD_SEND;
          next_r.index = 4'h0;
          next_r.outValid = 1'b1;
          next_r.outLast = 1'b0;
          next_r.busy = 1'b1;
        end
      end
      DSD_SEND: begin
        if (byteReady) begin
          if (r.index == `DSD_LAST_IDX) begin // see [R1]
            next_r.state = DSD_IDLE;
            next_r.outValid = 1'b0;
            next_r.outLast = 1'b0;
            next_r.busy = 1'b0;
          end else begin
            next_r.index = r.index + 4'h1;
            next_r.outLast = (r.index + 4'h1) == `DSD_LAST_IDX;
          end
        end
      end
      default: begin
        next_r.state = DSD_IDLE;
      end
    endcase
    // Byte content follows the index the frame moves to at this edge
    case (next_r.index)
      4'h0: frameByte = {1'b0, flags.badParam, 1'b0, flags.notSupported, flags.extDiag,
                         flags.cfgMismatch, flags.notReady, 1'b0}; // see [R4]
      4'h1: frameByte = `DSD_B1_FIXED | {2'b00, flags.syncSeen, flags.freezeSeen, flags.watchdogOn,
                         1'b0, flags.staticDiag, flags.needParam}; // see [R5]
      4'h2: frameByte = {flags.overflow, 7'h00}; // see [R6]
      4'h3: frameByte = masterAddr; // see [R7]
      4'h4: frameByte = IDENT[15:8]; // see [R10]
      4'h5: frameByte = IDENT[7:0]; // see [R10]
      4'h6: frameByte = `DSD_B6_VALUE; // see [R8] see [R11]
      4'h7: frameByte = next_r.message; // see [R9] see [R12]
      4'hB: frameByte = next_r.user[39:32]; // see [R3]
      4'hC: frameByte = next_r.user[31:24];
      4'hD: frameByte = next_r.user[23:16];
      4'hE: frameByte = next_r.user[15:8];
      4'hF: frameByte = next_r.user[7:0];
      default: frameByte = 8'h00; // see [R9]
    endcase
    next_r.outByte = next_r.outValid ? frameByte : 8'h00;
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign txByte = r.outByte;
  assign txValid = r.outValid;
  assign txLast = r.outLast;
  assign busy = r.busy;

  // Handshake steps shared by the frame properties
  sequence s_quiet_request;
    masterRequest && !busy;
  endsequence
  sequence s_host_rise;
    hostStart && !busy && !r.pending;
  endsequence
  sequence s_frame_open;
    !txValid ##1 txValid;
  endsequence
  sequence s_mid_taken;
    txValid && byteReady && !txLast;
  endsequence
  sequence s_last_taken;
    txValid && byteReady && txLast;
  endsequence
  sequence s_stalled;
    txValid && !byteReady;
  endsequence

  // Frame shape and handshake
  a_frame_length: assert property (@(posedge clock) disable iff (!reset_n) // see [R1]
    s_last_taken |=> !txValid)
    else $error("frame did not end");
  a_last_index: assert property (@(posedge clock) disable iff (!reset_n) // see [R1]
    (txValid && txLast) |-> (r.index == `DSD_LAST_IDX))
    else $error("last flag on wrong byte");
  a_last_marked: assert property (@(posedge clock) disable iff (!reset_n) // see [R1]
    (txValid && r.index == `DSD_LAST_IDX) |-> txLast)
    else $error("last byte not flagged");
  a_index_step: assert property (@(posedge clock) disable iff (!reset_n) // see [R1]
    s_mid_taken |=> (txValid && r.index == $past(r.index) + 4'h1))
    else $error("frame index skipped");
  a_stall_hold: assert property (@(posedge clock) disable iff (!reset_n) // see [R1]
    s_stalled |=> (txValid && $stable(r.index)))
    else $error("byte dropped while stalled");
  a_frame_opens: assert property (@(posedge clock) disable iff (!reset_n) // see [R1]
    s_frame_open |-> (r.index == 4'h0 && !txLast))
    else $error("frame did not open at byte 0");
  a_quiet_out: assert property (@(posedge clock) disable iff (!reset_n) // see [R1]
    !txValid |-> (txByte == 8'h00 && !txLast && !busy))
    else $error("idle outputs not quiet");

  // Report triggers
  a_request_start: assert property (@(posedge clock) disable iff (!reset_n) // see [R2]
    s_quiet_request |-> ##[1:3] txValid)
    else $error("request not served");
  a_error_start: assert property (@(posedge clock) disable iff (!reset_n) // see [R2]
    (errorEvent && !busy) |-> ##[1:3] txValid)
    else $error("error event not served");
  a_request_kept: assert property (@(posedge clock) disable iff (!reset_n) // see [R2]
    (busy && (masterRequest || errorEvent)) |=> r.pending)
    else $error("request in frame lost");
  a_idle_gap: assert property (@(posedge clock) disable iff (!reset_n) // see [R2]
    s_last_taken ##1 r.pending |=> txValid)
    else $error("held request not served");
  a_host_start: assert property (@(posedge clock) disable iff (!reset_n) // see [R13]
    s_host_rise |=> s_frame_open)
    else $error("host start not served");
  a_ignore_both: assert property (@(posedge clock) disable iff (!reset_n) // see [R14]
    (hostStatus == `DSD_STAT_IGNORED && !busy && !r.pending && !masterRequest && !errorEvent)
    |=> !r.pending)
    else $error("ignored status started");
  a_user_taken: assert property (@(posedge clock) disable iff (!reset_n) // see [R3]
    hostStart |=> (r.user == $past(hostData)))
    else $error("host bytes not taken");
  a_error_code: assert property (@(posedge clock) disable iff (!reset_n) // see [R12]
    errorEvent |=> (r.message == $past(errorCode)))
    else $error("error code not taken");
  a_host_code: assert property (@(posedge clock) disable iff (!reset_n) // see [R12]
    (hostStart && !errorEvent) |=> (r.message == `DSD_CODE_USER_VALID))
    else $error("user valid code not set");

  // Byte contents
  a_byte0_fixed: assert property (@(posedge clock) disable iff (!reset_n) // see [R4]
    (txValid && r.index == 4'h0) |-> (txByte[0] == 1'b0 && txByte[5] == 1'b0 && txByte[7] == 1'b0))
    else $error("byte 0 fixed bits wrong");
  a_byte1_fixed: assert property (@(posedge clock) disable iff (!reset_n) // see [R5]
    (txValid && r.index == 4'h1) |-> (txByte[2] && !txByte[7] && !txByte[6]))
    else $error("byte 1 fixed bits wrong");
  a_byte2_res: assert property (@(posedge clock) disable iff (!reset_n) // see [R6]
    (txValid && r.index == 4'h2) |-> (txByte[6:0] == 7'h00))
    else $error("byte 2 reserved set");
  a_byte3_addr: assert property (@(posedge clock) disable iff (!reset_n) // see [R7]
    (txValid && r.index == 4'h3) |-> (txByte == $past(masterAddr)))
    else $error("master address wrong");
  a_ident_order: assert property (@(posedge clock) disable iff (!reset_n) // see [R10]
    (txValid && r.index == 4'h4) |-> (txByte == IDENT[15:8]))
    else $error("ident high misplaced");
  a_ident_low: assert property (@(posedge clock) disable iff (!reset_n) // see [R10]
    (txValid && r.index == 4'h5) |-> (txByte == IDENT[7:0]))
    else $error("ident low misplaced");
  a_byte6_len: assert property (@(posedge clock) disable iff (!reset_n) // see [R11]
    (txValid && r.index == 4'h6) |-> (txByte == 8'h0A))
    else $error("byte 6 wrong");
  a_byte8_res: assert property (@(posedge clock) disable iff (!reset_n) // see [R9]
    (txValid && r.index == 4'h8) |-> (txByte == 8'h00))
    else $error("byte 8 not zero");
  a_spare_zero: assert property (@(posedge clock) disable iff (!reset_n) // see [R9]
    (txValid && (r.index == 4'h9 || r.index == 4'hA)) |-> (txByte == 8'h00))
    else $error("spare byte not zero");
  a_user_first: assert property (@(posedge clock) disable iff (!reset_n) // see [R3]
    (txValid && r.index == 4'hB) |-> (txByte == r.user[39:32]))
    else $error("byte 11 not host data");
endmodule
`default_nettype wire

/* File: shared/dsd_defines.svh */
// Purpose: constants for the diagnostic frame builder
// Assumes: byte-wide frame, sixteen bytes
// Notes: values fixed by the frame layout
`ifndef DSD_DEFINES_SVH
`define DSD_DEFINES_SVH
`define DSD_FRAME_LEN 5'h10
`define DSD_LAST_IDX 4'hF
`define DSD_USER_FIRST 4'hB
`define DSD_B6_VALUE 8'h0A
`define DSD_B1_FIXED 8'h04
`define DSD_CODE_USER_VALID 8'h40
`define DSD_STAT_VALID_BIT 0
`define DSD_STAT_DELETE_BIT 1
`define DSD_STAT_IGNORED 8'h03
`define DSD_IDENT_DEFAULT 16'h1234 // Arbitrary value
`endif

/* File: shared/dsd_pkg.sv */
// Purpose: types for the diagnostic frame builder
// Assumes: nothing beyond the defines header
// Notes: one state struct per module
package dsd_pkg;
  typedef enum logic [1:0] {
    DSD_IDLE = 2'b00,
    DSD_SEND = 2'b01
  } dsd_state_t;
  typedef struct packed {
    logic notReady;
    logic cfgMismatch;
    logic extDiag;
    logic notSupported;
    logic badParam;
    logic needParam;
    logic staticDiag;
    logic watchdogOn;
    logic freezeSeen;
    logic syncSeen;
    logic overflow;
  } dsd_flags_t;
  typedef struct packed {
    dsd_state_t state;
    logic [3:0] index;
    logic [7:0] outByte;
    logic outValid;
    logic outLast;
    logic pending;
    logic [7:0] prevStatus;
    logic [7:0] message;
    logic [39:0] user;
    logic busy;
  } dsd_regs_t;
endpackage

/* File: test/dsd_sink.sv */
// Purpose: byte sink standing in for the protocol engine
// Assumes: driven from the falling clock edge
// Notes: slow mode stalls on a pseudo-random pattern
`timescale 1ns/1ns
`default_nettype none
module dsd_sink (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic slow,
  output logic byteReady
);
  logic [7:0] lfsr = 8'h5B;
  initial byteReady = 1'b0;
  // Changes only off the sampling edge, so a byte is never half taken
  always @(negedge clock) begin
    lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    byteReady <= reset_n && (slow ? lfsr[0] : 1'b1);
  end
endmodule
`default_nettype wire

/* File: test/test_dsd_frame.sv */
// Purpose: self-checking bench for the diagnostic frame builder
// Assumes: flags and master address held steady inside a frame
// Notes: expected bytes are rebuilt from the frame layout
`timescale 1ns/1ns
`default_nettype none
module test_dsd_frame;
  import dsd_pkg::*;
  localparam logic [15:0] ID = 16'hA5C3; // Arbitrary value
  logic clock = 0, reset_n = 0, masterRequest = 0, errorEvent = 0, slow = 0;
  logic [7:0] errorCode = 8'h00, masterAddr = 8'h00, hostStatus = 8'h00, msg = 8'h00;
  logic [39:0] hostData = 40'h0, user = 40'h0;
  dsd_flags_t flags = '0;
  logic [7:0] txByte;
  logic byteReady, txValid, txLast, busy;
  logic [31:0] rng = 32'h0000C22E;
  int fails = 0, n_checks = 0, idx = 0, frames = 0;
  always #20 clock = ~clock;
  dsd_frame #(.IDENT(ID)) dut (.clock(clock), .reset_n(reset_n), .masterRequest(masterRequest),
    .errorEvent(errorEvent), .errorCode(errorCode), .flags(flags), .masterAddr(masterAddr),
    .hostStatus(hostStatus), .hostData(hostData), .byteReady(byteReady), .txByte(txByte),
    .txValid(txValid), .txLast(txLast), .busy(busy));
  dsd_sink sink (.clock(clock), .reset_n(reset_n), .slow(slow), .byteReady(byteReady));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] expect_byte(input int i);
    case (i)
      0: return {1'b0, flags.badParam, 1'b0, flags.notSupported, flags.extDiag, flags.cfgMismatch,
        flags.notReady, 1'b0};
      1: return {2'b00, flags.syncSeen, flags.freezeSeen, flags.watchdogOn, 1'b1, flags.staticDiag,
        flags.needParam};
      2: return {flags.overflow, 7'h00};
      3: return masterAddr;
      4: return ID[15:8];
      5: return ID[7:0];
      6: return 8'h0A;
      7: return msg;
      default: return (i >= 11) ? user[39 - 8 * (i - 11) -: 8] : 8'h00;
    endcase
  endfunction
  always @(posedge clock) begin
    if (reset_n && txValid === 1'b1 && byteReady) begin
      check(txByte, expect_byte(idx));
      check({7'h00, txLast}, {7'h00, idx == 15});
      idx = (idx == 15) ? 0 : idx + 1;
      if (txLast) frames++;
    end
  end
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic roll();
    rng = xorshift(rng);
    flags = dsd_flags_t'(rng[10:0]);
    masterAddr = rng[31:24];
    slow = rng[11];
  endtask
  // Kind 0 master request, 1 error event, 2 host start; waits for n frames
  task automatic go(input int kind, input int n);
    int f;
    f = frames;
    @(negedge clock);
    case (kind)
      0: masterRequest = 1'b1;
      1: errorEvent = 1'b1;
      default: hostStatus = 8'h01;
    endcase
    @(negedge clock);
    masterRequest = 1'b0;
    errorEvent = 1'b0;
    repeat (120 * n) if (frames < f + n) @(negedge clock);
    check(8'(frames - f), 8'(n));
    hostStatus = 8'h00;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #(40 * 8000);
    fails++;
    stop_test();
  end
  initial begin
    repeat (5) @(negedge clock);
    reset_n = 1'b1;
    go(0, 1);
    for (int c = 18; c <= 23; c++) begin
      roll();
      errorCode = 8'(c);
      msg = 8'(c);
      go(1, 1);
    end
    roll();
    hostData = {rng, rng[15:8]};
    user = hostData;
    msg = 8'h40;
    go(2, 1);
    @(negedge clock);
    hostStatus = 8'h03;
    repeat (6) @(negedge clock);
    check({7'h00, busy}, 8'h00);
    hostStatus = 8'h00;
    // A request in mid-frame must buy exactly one more frame
    fork
      go(0, 2);
      begin
        repeat (8) @(negedge clock);
        masterRequest = 1'b1;
        @(negedge clock);
        masterRequest = 1'b0;
      end
    join
    // No third frame may follow the held request
    repeat (8) @(negedge clock);
    check({7'h00, busy}, 8'h00);
    stop_test();
  end
endmodule
`default_nettype wire
